// *** hw/sswp_pkg.sv ***
// Package for the safety status word packer: bit positions, register map, field layouts.
// Assumes a 32-bit classic Wishbone register bus with word-aligned byte addresses.
package sswp_pkg;

	// Octet 0 bit positions
	localparam int unsigned O0_LS2 = 0;
	localparam int unsigned O0_LS1 = 1;
	localparam int unsigned O0_CSTOP = 4;
	localparam int unsigned O0_ESTOP = 5;
	localparam int unsigned O0_BRAKE = 6;
	localparam int unsigned O0_TOFF = 7;
	// Octet 1 bit positions
	localparam int unsigned O1_AR1 = 4;
	localparam int unsigned O1_AR0 = 5;
	localparam int unsigned O1_LS4 = 6;
	localparam int unsigned O1_LS3 = 7;
	// Octet 2 bit positions
	localparam int unsigned O2_FBSRC = 0;
	localparam int unsigned O2_MAXSPD = 1;
	localparam int unsigned O2_SM4 = 2;
	localparam int unsigned O2_SM3 = 3;
	localparam int unsigned O2_SM2 = 4;
	localparam int unsigned O2_SM1 = 5;
	localparam int unsigned O2_DIRN = 6;
	localparam int unsigned O2_DIRP = 7;
	// Octet 3: group b inputs at bits 0..3, group a at bits 4..7
	localparam int unsigned O3_GRPB_LSB = 0;
	localparam int unsigned O3_GRPA_LSB = 4;

	// Feedback source encoding
	localparam logic FB_ESTIMATE = 1'b0;
	localparam logic FB_ENCODER = 1'b1;

	// Register byte offsets
	localparam logic [7:0] REG_STATUS_WORD = 8'h00;
	localparam logic [7:0] REG_CONTROL = 8'h04;
	localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
	localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
	localparam logic [7:0] REG_MODULE_STATE = 8'h10;

	// Control register fields
	localparam int unsigned CTRL_FAILSAFE = 0;
	localparam int unsigned CTRL_CONFIG = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;

	// Interrupt status fields
	localparam int unsigned IRQ_UPDATE = 0;
	localparam int unsigned IRQ_FORCED = 1;
	localparam int unsigned IRQ_W = 2;

	// Packer state, one-hot
	typedef enum logic [2:0] {
		ST_WAIT = 3'b001,
		ST_RUN = 3'b010,
		ST_HOLD = 3'b100
	} sswp_state_t;

endpackage : sswp_pkg

// *** hw/sswp_irq.sv ***
// Sticky interrupt status with mask, cleared by writing one.
// Assumes events are one-cycle pulses in the CLK domain.
`timescale 1ns/10ps
module sswp_irq #(
	parameter int unsigned W = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Events and software access
	input wire logic [W-1:0] event_set,
	input wire logic [W-1:0] clear_ones,
	input wire logic clear_we,
	input wire logic [W-1:0] mask_wdata,
	input wire logic mask_we,
	// State out
	output logic [W-1:0] status,
	output logic [W-1:0] mask,
	output logic irq
);
	logic [W-1:0] status_reg, status_next, mask_reg, mask_next;

	// Set wins over a clear in the same cycle
	always_comb begin
		status_next = status_reg;
		mask_next = mask_reg;
		if (clear_we) begin
			status_next = status_next & ~clear_ones;
		end
		status_next = status_next | event_set;
		if (mask_we) begin
			mask_next = mask_wdata;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			status_reg <= '0;
			mask_reg <= '0;
		end else begin
			status_reg <= status_next;
			mask_reg <= mask_next;
		end
	end

	assign status = status_reg;
	assign mask = mask_reg;
	assign irq = |(status_reg & mask_reg);
endmodule // sswp_irq

// *** hw/sswp_sample.sv ***
// Sample register for a group of levels, loaded only on a sample strobe.
// Assumes the levels are synchronous to the clock.
`timescale 1ns/10ps
module sswp_sample #(
	parameter int unsigned W = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Sample control
	input wire logic load,
	input wire logic [W-1:0] d,
	// Held copy
	output logic [W-1:0] q
);
	logic [W-1:0] q_reg, q_next;

	// Hold between strobes so every octet comes from one sample
	always_comb begin
		q_next = q_reg;
		if (load) begin
			q_next = d;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			q_reg <= '0;
		end else begin
			q_reg <= q_next;
		end
	end

	assign q = q_reg;
endmodule // sswp_sample

// *** hw/sswp_top.sv ***
// Packs octets 0 to 3 of the safety status message from function and input levels.
// Assumes synchronous level inputs, a sample strobe from the message cycle logic,
// and a classic Wishbone master for the register file.
// Operation
// - Octet0 bit0: limited speed 2 under limit
// - Octet0 bit1: limited speed 1 under limit
// - Reserved bits are zero; host ignores them
// - Octet0 bits4-7: stop, estop, brake, torque-off
// - Octet1 bits4,5: accel range 1, 0
// - Octet1 bits6,7: limited speed 4, 3
// - Octet2 bit0: feedback source, 1 encoder
// - Octet2 bit1: max speed supervision active
// - Octet2 bits2-5: speed monitors 4 to 1
// - Octet2 bits6,7: negative then positive direction
// - Octet3: group b 4..1, group a 4..1
// - One means active, zero not active
// - All zero in fail-safe or configuration state
//
// Chosen here: the Wishbone register port and the placing of the registers.
`timescale 1ns/10ps
module sswp_top
	import sswp_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic ARST_N,
	// Limited speed, each already qualified by speed under limit
	input wire logic LIMITED_SPEED1_ON,
	input wire logic LIMITED_SPEED2_ON,
	input wire logic LIMITED_SPEED3_ON,
	input wire logic LIMITED_SPEED4_ON,
	// Stop and brake functions
	input wire logic CONTROLLED_STOP_ON,
	input wire logic EMERGENCY_STOP_ON,
	input wire logic BRAKE_CONTROL_ON,
	input wire logic TORQUE_OFF_ON,
	// Acceleration ranges
	input wire logic ACCEL_RANGE0_ON,
	input wire logic ACCEL_RANGE1_ON,
	// Speed supervision and feedback
	input wire logic FEEDBACK_IS_ENCODER,
	input wire logic MAX_SPEED_SUPERVISION_ON,
	input wire logic SPEED_MONITOR1_IN_WINDOW,
	input wire logic SPEED_MONITOR2_IN_WINDOW,
	input wire logic SPEED_MONITOR3_IN_WINDOW,
	input wire logic SPEED_MONITOR4_IN_WINDOW,
	input wire logic NEGATIVE_DIRECTION_GUARD_ON,
	input wire logic POSITIVE_DIRECTION_GUARD_ON,
	// Safe inputs, index 0 is input 1
	input wire logic [3:0] SAFE_IN_GROUP_A,
	input wire logic [3:0] SAFE_IN_GROUP_B,
	// Message cycle: sample strobe and module states
	input wire logic SAMPLE_STROBE,
	input wire logic FAILSAFE_STATE,
	input wire logic CONFIG_STATE,
	// Packed status octets
	output logic [31:0] STATUS_WORD,
	output logic STATUS_VALID,
	// Wishbone slave
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	output logic WB_ERR_O,
	// Interrupt
	output logic IRQ
);
	import sswp_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Raw octet assembly

	logic [31:0] raw_word, held_word;
	logic [7:0] oct0, oct1, oct2, oct3;
	logic forced_zero, take_sample;
	logic [1:0] ctrl_reg, ctrl_next;
	sswp_state_t state_reg, state_next;
	logic [31:0] word_reg, word_next;

	// Each bit is a plain active-high level; reserved bits stay at zero
	always_comb begin
		oct0 = 8'h00;
		oct1 = 8'h00;
		oct2 = 8'h00;
		oct3 = 8'h00;
		oct0[O0_LS2] = LIMITED_SPEED2_ON;
		oct0[O0_LS1] = LIMITED_SPEED1_ON;
		oct0[O0_CSTOP] = CONTROLLED_STOP_ON;
		oct0[O0_ESTOP] = EMERGENCY_STOP_ON;
		oct0[O0_BRAKE] = BRAKE_CONTROL_ON;
		oct0[O0_TOFF] = TORQUE_OFF_ON;
		oct1[O1_AR1] = ACCEL_RANGE1_ON;
		oct1[O1_AR0] = ACCEL_RANGE0_ON;
		oct1[O1_LS4] = LIMITED_SPEED4_ON;
		oct1[O1_LS3] = LIMITED_SPEED3_ON;
		// The host reads this only to qualify position validity
		oct2[O2_FBSRC] = FEEDBACK_IS_ENCODER ? FB_ENCODER : FB_ESTIMATE;
		oct2[O2_MAXSPD] = MAX_SPEED_SUPERVISION_ON;
		oct2[O2_SM4] = SPEED_MONITOR4_IN_WINDOW;
		oct2[O2_SM3] = SPEED_MONITOR3_IN_WINDOW;
		oct2[O2_SM2] = SPEED_MONITOR2_IN_WINDOW;
		oct2[O2_SM1] = SPEED_MONITOR1_IN_WINDOW;
		oct2[O2_DIRN] = NEGATIVE_DIRECTION_GUARD_ON;
		oct2[O2_DIRP] = POSITIVE_DIRECTION_GUARD_ON;
		// Input 4 lands in the lowest bit of each nibble
		for (int i = 0; i < 4; i++) begin
			oct3[O3_GRPB_LSB + i] = SAFE_IN_GROUP_B[3 - i];
			oct3[O3_GRPA_LSB + i] = SAFE_IN_GROUP_A[3 - i];
		end
		raw_word = {oct3, oct2, oct1, oct0};
	end

	////////////////////////////////////////////////////////////////////////////////
	// Coherent sample

	// Software may also hold the word at zero as if fail-safe or configuring
	assign forced_zero = FAILSAFE_STATE | CONFIG_STATE | ctrl_reg[CTRL_FAILSAFE]
		| ctrl_reg[CTRL_CONFIG];
	assign take_sample = SAMPLE_STROBE;

	sswp_sample #(
		.W(32)
	) u_sample (
		.clk(CLK),
		.arst_n(ARST_N),
		.load(take_sample),
		.d(raw_word),
		.q(held_word)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Output state machine

	// Output word follows the held sample one cycle later, zero while forced
	always_comb begin
		state_next = state_reg;
		word_next = word_reg;
		case (state_reg)
			ST_WAIT: begin
				word_next = 32'h0000_0000;
				if (take_sample && !forced_zero) begin
					state_next = ST_RUN;
				end else if (take_sample) begin
					state_next = ST_HOLD;
				end
			end
			ST_RUN: begin
				word_next = held_word;
				if (forced_zero) begin
					state_next = ST_HOLD;
					word_next = 32'h0000_0000;
				end
			end
			ST_HOLD: begin
				word_next = 32'h0000_0000;
				if (!forced_zero && take_sample) begin
					state_next = ST_RUN;
				end
			end
			default: begin
				state_next = ST_WAIT;
				word_next = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state_reg <= ST_WAIT;
			word_reg <= 32'h0000_0000;
		end else begin
			state_reg <= state_next;
			word_reg <= word_next;
		end
	end

	assign STATUS_WORD = word_reg;
	assign STATUS_VALID = (state_reg == ST_RUN);

	////////////////////////////////////////////////////////////////////////////////
	// Wishbone slave and interrupts

	logic ack_reg, ack_next, err_reg, err_next;
	logic [31:0] rdata_reg, rdata_next;
	logic req, wr, rd_hit;
	logic [IRQ_W-1:0] irq_status, irq_mask, irq_events;
	logic irq_clr_we, irq_mask_we, run_d_reg;

	assign req = WB_CYC_I & WB_STB_I & ~ack_reg & ~err_reg;
	assign wr = req & WB_WE_I & WB_SEL_I[0];
	assign irq_clr_we = wr && (WB_ADR_I == REG_IRQ_STATUS);
	assign irq_mask_we = wr && (WB_ADR_I == REG_IRQ_MASK);
	// Events: entry into the live run state, and entry into the forced-zero hold
	assign irq_events = {(state_next == ST_HOLD) && (state_reg != ST_HOLD),
		(state_reg == ST_RUN) && !run_d_reg};

	sswp_irq #(
		.W(IRQ_W)
	) u_irq (
		.clk(CLK),
		.arst_n(ARST_N),
		.event_set(irq_events),
		.clear_ones(WB_DAT_I[IRQ_W-1:0]),
		.clear_we(irq_clr_we),
		.mask_wdata(WB_DAT_I[IRQ_W-1:0]),
		.mask_we(irq_mask_we),
		.status(irq_status),
		.mask(irq_mask),
		.irq(IRQ)
	);

	// Decode: one-cycle answer, error on an unmapped address
	always_comb begin
		ack_next = 1'b0;
		err_next = 1'b0;
		rdata_next = 32'h0000_0000;
		ctrl_next = ctrl_reg;
		rd_hit = 1'b1;
		if (WB_ADR_I == REG_STATUS_WORD) begin
			rdata_next = word_reg;
		end else if (WB_ADR_I == REG_CONTROL) begin
			rdata_next = {30'h0000_0000, ctrl_reg};
			if (wr) begin
				ctrl_next = WB_DAT_I[1:0];
			end
		end else if (WB_ADR_I == REG_IRQ_STATUS) begin
			rdata_next = {30'h0000_0000, irq_status};
		end else if (WB_ADR_I == REG_IRQ_MASK) begin
			rdata_next = {30'h0000_0000, irq_mask};
		end else if (WB_ADR_I == REG_MODULE_STATE) begin
			rdata_next = {29'h0000_0000, state_reg};
		end else begin
			rd_hit = 1'b0;
		end
		if (req) begin
			ack_next = rd_hit;
			err_next = ~rd_hit;
		end
		if (!req || WB_WE_I) begin
			rdata_next = 32'h0000_0000;
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ack_reg <= 1'b0;
			err_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			ctrl_reg <= CTRL_RESET;
			run_d_reg <= 1'b0;
		end else begin
			ack_reg <= ack_next;
			err_reg <= err_next;
			rdata_reg <= rdata_next;
			ctrl_reg <= ctrl_next;
			run_d_reg <= (state_reg == ST_RUN);
		end
	end

	assign WB_ACK_O = ack_reg;
	assign WB_ERR_O = err_reg;
	assign WB_DAT_O = rdata_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions

	sequence s_sampled_live;
		take_sample && !forced_zero && (state_reg != ST_RUN || !forced_zero);
	endsequence

	zero_when_forced_a: assert property (@(posedge CLK) disable iff (!ARST_N)
		forced_zero |=> (STATUS_WORD == 32'h0000_0000))
		else $error("status word not zero while forced");
	reserved_zero_a: assert property (@(posedge CLK) disable iff (!ARST_N)
		(STATUS_WORD[3:2] == 2'h0) && (STATUS_WORD[11:8] == 4'h0))
		else $error("reserved bits not zero");
	zero_before_sample_a: assert property (@(posedge CLK) disable iff (!ARST_N)
		(state_reg == ST_WAIT) |-> (STATUS_WORD == 32'h0000_0000))
		else $error("status word set before first sample");
	coherent_word_a: assert property (@(posedge CLK) disable iff (!ARST_N)
		s_sampled_live ##1 (!take_sample && !forced_zero)[*2] |->
		(STATUS_WORD == $past(raw_word, 2)))
		else $error("status word mixes samples");
	hold_between_a: assert property (@(posedge CLK) disable iff (!ARST_N)
		((state_reg == ST_RUN) && !take_sample && !forced_zero)[*2]
		|=> $stable(STATUS_WORD))
		else $error("status word changed without a sample");
	octet0_map_a: assert property (@(posedge CLK) disable iff (!ARST_N)
		s_sampled_live ##1 !forced_zero |=>
		(STATUS_WORD[O0_LS2] == $past(LIMITED_SPEED2_ON, 2)))
		else $error("octet 0 bit 0 wrong");
	octet3_map_a: assert property (@(posedge CLK) disable iff (!ARST_N)
		s_sampled_live ##1 !forced_zero |=>
		(STATUS_WORD[O3_GRPA_LSB + 3 + 24] == $past(SAFE_IN_GROUP_A[0], 2)))
		else $error("octet 3 group a input 1 wrong");
	feedback_bit_a: assert property (@(posedge CLK) disable iff (!ARST_N)
		s_sampled_live ##1 !forced_zero |=>
		(STATUS_WORD[O2_FBSRC + 16] == $past(FEEDBACK_IS_ENCODER, 2)))
		else $error("feedback source bit wrong");
	wb_ack_once_a: assert property (@(posedge CLK) disable iff (!ARST_N)
		WB_ACK_O |=> !WB_ACK_O)
		else $error("ack held more than one cycle");
endmodule // sswp_top

// *** dv/sswp_host.sv ***
// Host side model: keeps the last live status word it was offered.
// Assumes the word and its valid flag are registered in the CLK domain.
`timescale 1ns/10ps
module sswp_host (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Status message from the packer
	input wire logic [31:0] status_word,
	input wire logic status_valid,
	// What the host acts on
	output logic [31:0] view,
	output logic pos_src_encoder
);
	localparam logic [31:0] RSVD = 32'h0000_0f0c;
	////////////////////////////////////////
	// Reserved positions are dropped so a stray one can never steer the host
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			view <= 32'h0;
		end else if (status_valid) begin
			view <= status_word & ~RSVD;
		end
	end
	// Source bit only qualifies the position-valid flag, nothing else
	assign pos_src_encoder = view[16];
endmodule // sswp_host

// *** dv/tb_top.sv ***
// Testbench for the status word packer: every status bit, coherence,
// forced zero, interrupts and bus errors. Assumes one 100 MHz clock.
`timescale 1ns/10ps
module tb_top;
	import sswp_pkg::*;
	logic CLK, ARST_N, stb, cyc, we, ack, err, irq, valid, fs, cf;
	logic [3:0] sel;
	logic [7:0] adr;
	logic [31:0] wdat, rdat, word, hview;
	logic [25:0] inv;
	int failures, checks_done;
	////////////////////////////////////////
	// Design and host model
	sswp_top dut(.CLK(CLK), .ARST_N(ARST_N),
		.LIMITED_SPEED1_ON(inv[0]), .LIMITED_SPEED2_ON(inv[1]),
		.LIMITED_SPEED3_ON(inv[2]), .LIMITED_SPEED4_ON(inv[3]),
		.CONTROLLED_STOP_ON(inv[4]), .EMERGENCY_STOP_ON(inv[5]),
		.BRAKE_CONTROL_ON(inv[6]), .TORQUE_OFF_ON(inv[7]),
		.ACCEL_RANGE0_ON(inv[8]), .ACCEL_RANGE1_ON(inv[9]),
		.FEEDBACK_IS_ENCODER(inv[10]), .MAX_SPEED_SUPERVISION_ON(inv[11]),
		.SPEED_MONITOR1_IN_WINDOW(inv[12]), .SPEED_MONITOR2_IN_WINDOW(inv[13]),
		.SPEED_MONITOR3_IN_WINDOW(inv[14]), .SPEED_MONITOR4_IN_WINDOW(inv[15]),
		.NEGATIVE_DIRECTION_GUARD_ON(inv[16]), .POSITIVE_DIRECTION_GUARD_ON(inv[17]),
		.SAFE_IN_GROUP_A(inv[21:18]), .SAFE_IN_GROUP_B(inv[25:22]),
		.SAMPLE_STROBE(stb), .FAILSAFE_STATE(fs), .CONFIG_STATE(cf),
		.STATUS_WORD(word), .STATUS_VALID(valid),
		.WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we), .WB_ADR_I(adr),
		.WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
		.WB_ACK_O(ack), .WB_ERR_O(err), .IRQ(irq));
	sswp_host host(.clk(CLK), .arst_n(ARST_N), .status_word(word),
		.status_valid(valid), .view(hview), .pos_src_encoder());
	initial begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end
	////////////////////////////////////////
	// Expected word, bit by bit from the layout
	function automatic logic [31:0] exp_w(logic [25:0] v);
		logic [31:0] w;
		w = '0;
		w[0] = v[1];
		w[1] = v[0];
		w[7:4] = v[7:4];
		w[12] = v[9];
		w[13] = v[8];
		w[14] = v[3];
		w[15] = v[2];
		w[16] = v[10];
		w[17] = v[11];
		w[23:22] = v[17:16];
		for (int i = 0; i < 4; i++) begin
			w[21-i] = v[12+i];
			w[27-i] = v[22+i];
			w[31-i] = v[18+i];
		end
		return w;
	endfunction
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task stop_test;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// One classic cycle; ack or err is sampled at a rising edge, released right there
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		@(posedge CLK);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		n = 0;
		@(posedge CLK);
		while (n < 50 && ack !== 1'b1 && err !== 1'b1) begin
			@(posedge CLK);
			n++;
		end
		q = rdat;
		e = err;
		cyc <= 1'b0;
		we <= 1'b0;
		if (n == 50) begin
			failures++;
			stop_test;
		end
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] q;
		logic e;
		wb(1'b0, a, 32'h0, q, e);
		chk(q, x);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		wb(1'b1, a, d, q, e);
	endtask
	// Sample v, then move inputs to n so a mixed sample would show
	task smp(input logic [25:0] v, input logic [25:0] n);
		@(posedge CLK);
		inv <= v;
		stb <= 1'b1;
		@(posedge CLK);
		stb <= 1'b0;
		inv <= n;
		repeat (2) @(posedge CLK);
		@(negedge CLK);
	endtask
	////////////////////////////////////////
	// Main sequence
	initial begin
		logic [31:0] q;
		logic e;
		ARST_N = 1'b0;
		{cyc, stb, we, adr, wdat, inv, fs, cf} = '0;
		sel = 4'hf;
		failures = 0;
		checks_done = 0;
		repeat (3) @(posedge CLK);
		ARST_N <= 1'b1;
		inv <= 26'h3fffffe;
		repeat (3) @(negedge CLK);
		chk(word, 32'h0);
		chk({31'h0, valid}, 32'h0);
		rdc(REG_MODULE_STATE, 32'h1);
		$display("test reset done");
		for (int i = 0; i < 26; i++) begin
			smp(26'h1 << i, ~(26'h1 << i));
			chk(word, exp_w(26'h1 << i));
		end
		smp(26'h3ffffff, 26'h0);
		@(negedge CLK);
		chk(word, exp_w(26'h3ffffff));
		chk(hview, exp_w(26'h3ffffff));
		rdc(REG_STATUS_WORD, exp_w(26'h3ffffff));
		$display("test bit map done");
		wr(REG_CONTROL, 32'h1);
		@(negedge CLK);
		chk(word, 32'h0);
		rdc(REG_IRQ_STATUS, 32'h3);
		chk({31'h0, irq}, 32'h0);
		wr(REG_IRQ_MASK, 32'h2);
		chk({31'h0, irq}, 32'h1);
		wr(REG_IRQ_STATUS, 32'h2);
		chk({31'h0, irq}, 32'h0);
		rdc(REG_IRQ_STATUS, 32'h1);
		wr(REG_CONTROL, 32'h0);
		repeat (3) @(negedge CLK);
		chk(word, 32'h0);
		smp(26'h3fffffe, 26'h3fffffe);
		chk(word, exp_w(26'h3fffffe));
		wr(REG_CONTROL, 32'h2);
		@(negedge CLK);
		chk(word, 32'h0);
		wr(REG_CONTROL, 32'h0);
		// A write without byte lane 0 is acknowledged but changes nothing
		sel <= 4'he;
		wr(REG_CONTROL, 32'h1);
		sel <= 4'hf;
		rdc(REG_CONTROL, 32'h0);
		wr(REG_IRQ_STATUS, 32'h3);
		wr(REG_IRQ_MASK, 32'h1);
		chk({31'h0, irq}, 32'h0);
		smp(26'h3ffffff, 26'h3ffffff);
		chk(word, exp_w(26'h3ffffff));
		chk({31'h0, valid}, 32'h1);
		chk({31'h0, irq}, 32'h1);
		rdc(REG_MODULE_STATE, 32'h2);
		// Module state pins force the word exactly like the control bits
		@(posedge CLK);
		fs <= 1'b1;
		repeat (2) @(negedge CLK);
		chk(word, 32'h0);
		chk({31'h0, valid}, 32'h0);
		@(posedge CLK);
		fs <= 1'b0;
		cf <= 1'b1;
		rdc(REG_MODULE_STATE, 32'h4);
		smp(26'h3ffffff, 26'h3ffffff);
		chk(word, 32'h0);
		@(posedge CLK);
		cf <= 1'b0;
		smp(26'h3ffffff, 26'h0);
		chk(word, exp_w(26'h3ffffff));
		$display("test force done");
		wb(1'b0, 8'h20, 32'h0, q, e);
		chk({31'h0, e}, 32'h1);
		$display("test unmapped done");
		stop_test;
	end
endmodule // tb_top
